// >>> include/csru_pkg.sv
// Purpose: shared constants and carriers for the chip select and ready unit
// Assumes: 20-bit physical addresses, 32-bit AHB-Lite register words
// Notes:   register layouts are local to this unit
package csru_pkg;
	localparam int        ADDR_W       = 20;
	localparam int        SIZE_W       = 8;
	localparam int        RDY_W        = 3;
	// register byte offsets
	localparam logic [7:0] OFS_UPPER    = 8'h00;
	localparam logic [7:0] OFS_LOWER    = 8'h04;
	localparam logic [7:0] OFS_MID_BASE = 8'h08;
	localparam logic [7:0] OFS_MPC      = 8'h0C;
	localparam logic [7:0] OFS_PBC      = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;
	// field positions
	localparam int        F_RDY_LSB    = 0;
	localparam int        F_IGN_BIT    = 2;
	localparam int        F_SIZE_LSB   = 8;
	localparam int        F_BASE_LSB   = 10;
	localparam int        F_BASE_W     = 10;
	localparam int        F_OPT_BIT    = 7;
	localparam int        F_IO_BIT     = 6;
	localparam int        F_ACT_BIT    = 8;
	// reset values: top 1K, 3 wait states, external ready factored
	localparam logic [RDY_W-1:0]  UPPER_RDY_RST = 3'h3;
	localparam logic [SIZE_W-1:0] UPPER_SIZE_RST = 8'h00;
	// region granules
	localparam int        KB_SHIFT     = 10;
	localparam int        PAREA_SHIFT  = 7;
	localparam int        N_MID        = 4;
	localparam int        N_PER        = 7;
	// internal control register block (256 bytes)
	localparam logic [ADDR_W-1:0] CTRL_BASE = 20'hFFF00;
	localparam int        CTRL_SHIFT   = 8;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef struct packed {
		logic              start;
		logic              done;
		logic [ADDR_W-1:0] addr;
		logic              is_io;
		logic              is_fetch;
		logic              ext_master;
	} csru_cyc_t;

	typedef struct packed {
		logic [RDY_W-1:0]  rdy;
		logic [SIZE_W-1:0] size;
	} csru_area_t;
endpackage : csru_pkg

// >>> src/csru_range_match.sv
// Purpose: one address window compare
// Assumes: lo inclusive, hi exclusive, 21-bit bounds allow the top of space
// Notes:   pure combinational
module csru_range_match (
	input  wire logic [csru_pkg::ADDR_W-1:0] addr,
	input  wire logic [csru_pkg::ADDR_W:0]   lo,
	input  wire logic [csru_pkg::ADDR_W:0]   hi,
	output logic                             match
);
	logic [csru_pkg::ADDR_W:0] a_ext;

	assign a_ext = {1'b0, addr};
	assign match = (a_ext >= lo) && (a_ext < hi);
endmodule : csru_range_match

// >>> src/csru_wait_gen.sv
// Purpose: wait state counter and internal ready for one bus cycle
// Assumes: start is a one-cycle pulse, ext_rdy already synchronised
// Notes:   ready is a one-cycle pulse
module csru_wait_gen (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       start,
	input  wire logic                       done,
	input  wire logic [csru_pkg::RDY_W-1:0] ctl,
	input  wire logic                       ext_rdy,
	output logic                            ready,
	output logic                            busy
);
	typedef enum logic [1:0] {
		W_IDLE = 2'b01,
		W_WAIT = 2'b10
	} csru_wstate_t;

	csru_wstate_t                st_r;
	logic [1:0]                  cnt_r;
	logic [csru_pkg::RDY_W-1:0]  ctl_r;

	// ready needs the count spent and, unless ignored, external ready
	assign ready = (st_r == W_WAIT) && (cnt_r == 2'h0)
		&& (ctl_r[csru_pkg::F_IGN_BIT] || ext_rdy);
	assign busy  = (st_r == W_WAIT);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r  <= W_IDLE;
			cnt_r <= 2'h0;
			ctl_r <= 3'h0;
		end else begin
			case (st_r)
				W_IDLE: begin
					if (start) begin
						st_r  <= W_WAIT;
						cnt_r <= ctl[1:0];
						ctl_r <= ctl;
					end
				end
				W_WAIT: begin
					if (ready || done) begin
						st_r <= W_IDLE;
					end else if (cnt_r != 2'h0) begin
						cnt_r <= cnt_r - 2'h1;
					end
				end
				default: begin
					st_r <= W_IDLE;
				end
			endcase
		end
	end
endmodule : csru_wait_gen

// >>> src/csru_top.sv
// Purpose: chip select decode and internal ready generation
// Assumes: bus cycle descriptor and grant come from logic on clk
// Notes:   selects are registered, active low, driven at all times
// Function
// - only internal CPU or DMA cycles may activate any select output.
// - selects stay actively driven during external master ownership; outside logic selects.
// - six memory selects: upper, lower and four mid-range.
// - upper region ends at top address, lower starts at zero; size sets other bound.
// - after reset upper select covers top 1K, 3 waits, external ready factored.
// - other selects stay off until all their control registers are accessed.
// - seven peripheral selects, consecutive 128-byte areas from base, memory or I/O.
// - peripheral selects wait until both peripheral configuration registers are accessed.
// - option makes sixth and seventh peripheral outputs show latched A1, A2.
// - address outputs high after reset until both registers accessed and option set.
// - internal ready is produced for every access any select responds to.
// - two low ready bits give zero to three wait states.
// - third ready bit clear waits for external ready too; set ignores it.
// - overlapping areas activate all their selects together.
// - control block overlap delays select timing; external data is ignored.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
module csru_top (
	input  wire logic                             clk,
	input  wire logic                             resetn,
	input  wire logic                             hsel,
	input  wire logic [31:0]                      haddr,
	input  wire logic [1:0]                       htrans,
	input  wire logic                             hwrite,
	input  wire logic [2:0]                       hsize,
	input  wire logic [31:0]                      hwdata,
	input  wire logic                             hready,
	output logic      [31:0]                      hrdata,
	output logic                                  hreadyout,
	output logic                                  hresp,
	input  wire csru_pkg::csru_cyc_t              cyc,
	input  wire logic                             bus_grant_ack,
	input  wire logic                             async_ready_in,
	input  wire logic                             sync_ready_in,
	output logic                                  upper_mem_select_n,
	output logic                                  lower_mem_select_n,
	output logic      [csru_pkg::N_MID-1:0]       mid_mem_selects_n,
	output logic      [csru_pkg::N_PER-1:0]       periph_selects_n,
	output logic                                  int_ready,
	output logic                                  ext_data_ignore
);
	localparam int AW = csru_pkg::ADDR_W;

	logic                 rst_s1_r, rst_n_r;
	logic                 async_ready_in_s1_r, async_ready_in_r, sync_ready_in_s1_r, sync_ready_in_r;
	// registers
	csru_pkg::csru_area_t upper_r, lower_r, mid_r;
	logic [csru_pkg::F_BASE_W-1:0] mid_base_r, per_base_r;
	logic                 opt_addr_r, per_io_r;
	logic [csru_pkg::RDY_W-1:0] per_rdy_r;
	logic [4:0]           acc_r;
	// bus slave
	logic                 dp_wr_r;
	logic [7:0]           dp_ofs_r;
	logic                 ap_take;
	logic [7:0]           ap_ofs;
	// bus cycle
	logic                 act_r, first_r, int_r, io_r, fetch_r;
	logic [AW-1:0]        addr_r;
	// decode
	logic                 m_up, m_lo, m_ctrl;
	logic [csru_pkg::N_MID-1:0] m_mid;
	logic [csru_pkg::N_PER-1:0] m_per;
	logic                 en_lo, en_mid, en_per;
	logic                 hit_up, hit_lo, any_mid, any_per, any_hit, sel_ok;
	logic [csru_pkg::RDY_W-1:0] rdy_sel;
	logic [AW:0]          up_lo, lo_hi, mid_lo, q_sz, per_lo;
	logic                 ext_rdy, wg_ready, wg_busy;

	// reset release through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// ready pins come from outside the clock domain
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			async_ready_in_s1_r <= 1'b0;
			async_ready_in_r    <= 1'b0;
			sync_ready_in_s1_r <= 1'b0;
			sync_ready_in_r    <= 1'b0;
		end else begin
			async_ready_in_s1_r <= async_ready_in;
			async_ready_in_r    <= async_ready_in_s1_r;
			sync_ready_in_s1_r <= sync_ready_in;
			sync_ready_in_r    <= sync_ready_in_s1_r;
		end
	end
	assign ext_rdy = async_ready_in_r | sync_ready_in_r;

	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ap_take   = hsel && hready && (htrans == csru_pkg::HTRANS_NONSEQ
		|| htrans == csru_pkg::HTRANS_SEQ);
	assign ap_ofs    = haddr[7:0];

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			dp_wr_r  <= 1'b0;
			dp_ofs_r <= 8'h00;
		end else begin
			dp_wr_r  <= ap_take && hwrite;
			dp_ofs_r <= ap_take ? ap_ofs : 8'hFF;
		end
	end

	// read data is captured in the address phase
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			case (ap_ofs)
				csru_pkg::OFS_UPPER:    hrdata <= {16'h0000, upper_r.size, 5'h00, upper_r.rdy};
				csru_pkg::OFS_LOWER:    hrdata <= {16'h0000, lower_r.size, 5'h00, lower_r.rdy};
				csru_pkg::OFS_MID_BASE: hrdata <= {12'h000, mid_base_r, 10'h000};
				csru_pkg::OFS_MPC:      hrdata <= {16'h0000, mid_r.size, opt_addr_r, 4'h0,
					mid_r.rdy};
				csru_pkg::OFS_PBC:      hrdata <= {12'h000, per_base_r, 3'h0, per_io_r, 3'h0,
					per_rdy_r};
				csru_pkg::OFS_STATUS:   hrdata <= {22'h000000, wg_busy, act_r, 3'h0, acc_r};
				default:                hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// any access, read or write, arms the function behind a register
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			acc_r <= 5'h00;
		end else if (ap_take) begin
			case (ap_ofs)
				csru_pkg::OFS_UPPER:    acc_r[0] <= 1'b1;
				csru_pkg::OFS_LOWER:    acc_r[1] <= 1'b1;
				csru_pkg::OFS_MID_BASE: acc_r[2] <= 1'b1;
				csru_pkg::OFS_MPC:      acc_r[3] <= 1'b1;
				csru_pkg::OFS_PBC:      acc_r[4] <= 1'b1;
				default:                acc_r    <= acc_r;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			upper_r    <= '{rdy: csru_pkg::UPPER_RDY_RST, size: csru_pkg::UPPER_SIZE_RST};
			lower_r    <= '{rdy: 3'h0, size: 8'h00};
			mid_r      <= '{rdy: 3'h0, size: 8'h00};
			mid_base_r <= 10'h000;
			per_base_r <= 10'h000;
			opt_addr_r <= 1'b0;
			per_io_r   <= 1'b0;
			per_rdy_r  <= 3'h0;
		end else if (dp_wr_r) begin
			case (dp_ofs_r)
				csru_pkg::OFS_UPPER: begin
					upper_r.rdy  <= hwdata[csru_pkg::F_RDY_LSB +: csru_pkg::RDY_W];
					upper_r.size <= hwdata[csru_pkg::F_SIZE_LSB +: csru_pkg::SIZE_W];
				end
				csru_pkg::OFS_LOWER: begin
					lower_r.rdy  <= hwdata[csru_pkg::F_RDY_LSB +: csru_pkg::RDY_W];
					lower_r.size <= hwdata[csru_pkg::F_SIZE_LSB +: csru_pkg::SIZE_W];
				end
				csru_pkg::OFS_MID_BASE: begin
					mid_base_r <= hwdata[csru_pkg::F_BASE_LSB +: csru_pkg::F_BASE_W];
				end
				csru_pkg::OFS_MPC: begin
					mid_r.rdy  <= hwdata[csru_pkg::F_RDY_LSB +: csru_pkg::RDY_W];
					mid_r.size <= hwdata[csru_pkg::F_SIZE_LSB +: csru_pkg::SIZE_W];
					opt_addr_r <= hwdata[csru_pkg::F_OPT_BIT];
				end
				csru_pkg::OFS_PBC: begin
					per_rdy_r  <= hwdata[csru_pkg::F_RDY_LSB +: csru_pkg::RDY_W];
					per_io_r   <= hwdata[csru_pkg::F_IO_BIT];
					per_base_r <= hwdata[csru_pkg::F_BASE_LSB +: csru_pkg::F_BASE_W];
				end
				default: begin
					opt_addr_r <= opt_addr_r;
				end
			endcase
		end
	end

	// latch the bus cycle; external master cycles are marked not internal
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			act_r   <= 1'b0;
			first_r <= 1'b0;
			int_r   <= 1'b0;
			io_r    <= 1'b0;
			fetch_r <= 1'b0;
			addr_r  <= '0;
		end else if (cyc.start) begin
			act_r   <= 1'b1;
			first_r <= 1'b1;
			int_r   <= !cyc.ext_master && !bus_grant_ack;
			io_r    <= cyc.is_io;
			fetch_r <= cyc.is_fetch;
			addr_r  <= cyc.addr;
		end else begin
			first_r <= 1'b0;
			if (cyc.done || wg_ready) begin
				act_r <= 1'b0;
			end
		end
	end

	// window bounds, all 21 bits so the top of space is reachable
	assign up_lo  = {1'b1, {AW{1'b0}}}
		- (({{(AW+1-csru_pkg::SIZE_W){1'b0}}, upper_r.size} + 21'h1) << csru_pkg::KB_SHIFT);
	assign lo_hi  = ({{(AW+1-csru_pkg::SIZE_W){1'b0}}, lower_r.size} + 21'h1)
		<< csru_pkg::KB_SHIFT;
	assign mid_lo = {1'b0, mid_base_r, {csru_pkg::F_BASE_LSB{1'b0}}};
	assign q_sz   = ({{(AW+1-csru_pkg::SIZE_W){1'b0}}, mid_r.size} + 21'h1)
		<< csru_pkg::KB_SHIFT;
	assign per_lo = {1'b0, per_base_r, {csru_pkg::F_BASE_LSB{1'b0}}};

	csru_range_match u_up (
		.addr  (addr_r),
		.lo    (up_lo),
		.hi    ({1'b1, {AW{1'b0}}}),
		.match (m_up)
	);

	csru_range_match u_lo (
		.addr  (addr_r),
		.lo    ({(AW+1){1'b0}}),
		.hi    (lo_hi),
		.match (m_lo)
	);

	csru_range_match u_ctrl (
		.addr  (addr_r),
		.lo    ({1'b0, csru_pkg::CTRL_BASE}),
		.hi    ({1'b0, csru_pkg::CTRL_BASE} + (21'h1 << csru_pkg::CTRL_SHIFT)),
		.match (m_ctrl)
	);

	// four ascending quarters of the mid block
	for (genvar q = 0; q < csru_pkg::N_MID; q++) begin : g_mid
		logic [AW:0] qlo;
		assign qlo = mid_lo + q_sz * 21'(q);
		csru_range_match u_mq (
			.addr  (addr_r),
			.lo    (qlo),
			.hi    (qlo + q_sz),
			.match (m_mid[q])
		);
	end

	// seven consecutive 128-byte areas above the base
	for (genvar p = 0; p < csru_pkg::N_PER; p++) begin : g_per
		logic [AW:0] plo;
		assign plo = per_lo + (21'(p) << csru_pkg::PAREA_SHIFT);
		csru_range_match u_pa (
			.addr  (addr_r),
			.lo    (plo),
			.hi    (plo + (21'h1 << csru_pkg::PAREA_SHIFT)),
			.match (m_per[p])
		);
	end

	assign en_lo  = acc_r[1];
	assign en_mid = acc_r[2] && acc_r[3];
	assign en_per = acc_r[3] && acc_r[4];

	// control block overlap holds selects off for the first cycle
	assign sel_ok  = act_r && int_r && !(m_ctrl && first_r);
	assign hit_up  = !io_r && m_up;
	assign hit_lo  = !io_r && m_lo && en_lo;
	assign any_mid = !io_r && en_mid && (|m_mid);
	assign any_per = (io_r == per_io_r) && en_per && (|m_per);
	assign any_hit = hit_up || hit_lo || any_mid || any_per;

	// overlapping areas share one ready setting; first match is used
	always_comb begin
		rdy_sel = per_rdy_r;
		if (hit_up) begin
			rdy_sel = upper_r.rdy;
		end else if (hit_lo) begin
			rdy_sel = lower_r.rdy;
		end else if (any_mid) begin
			rdy_sel = mid_r.rdy;
		end
	end

	// each select is decoded on its own so overlaps fire together
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			upper_mem_select_n <= 1'b1;
			lower_mem_select_n <= 1'b1;
			mid_mem_selects_n  <= '1;
			periph_selects_n   <= '1;
		end else begin
			// driven, never floated, while an external master owns the bus; high except the latched A1, A2 outputs, which hold their value
			upper_mem_select_n <= !(sel_ok && hit_up);
			lower_mem_select_n <= !(sel_ok && hit_lo);
			mid_mem_selects_n  <= ~({csru_pkg::N_MID{sel_ok && !io_r && en_mid}} & m_mid);
			periph_selects_n[4:0] <= ~({5{sel_ok && (io_r == per_io_r) && en_per}}
				& m_per[4:0]);
			if (en_per && opt_addr_r) begin
				// latched A1, A2 held for the whole cycle
				if (act_r && int_r) begin
					periph_selects_n[5] <= addr_r[1];
					periph_selects_n[6] <= addr_r[2];
				end
			end else begin
				periph_selects_n[6:5] <= ~({2{sel_ok && (io_r == per_io_r) && en_per}}
					& m_per[6:5]);
			end
		end
	end

	// external data is discarded when the control block answers
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ext_data_ignore <= 1'b0;
		end else begin
			ext_data_ignore <= act_r && int_r && m_ctrl;
		end
	end

	// wait states start once the select decode has settled
	csru_wait_gen u_wait (
		.clk     (clk),
		.rst_n   (rst_n_r),
		.start   (first_r && int_r && any_hit),
		.done    (cyc.done),
		.ctl     (rdy_sel),
		.ext_rdy (ext_rdy),
		.ready   (wg_ready),
		.busy    (wg_busy)
	);

	assign int_ready = wg_ready;

	// fetch flag latched for the current cycle but not used or shown in status
	logic unused_fetch;
	assign unused_fetch = fetch_r;
endmodule : csru_top

// >>> bench/csru_mem_model.sv
// Purpose: memory and peripheral devices answering external ready
// Assumes: selects arrive active low and registered
// Notes:   delay is set by the bench so answers can be prompt or slow
module csru_mem_model (
	input  wire logic       clk,
	input  wire logic       sel_any_n,
	input  wire logic       slow,
	input  wire logic [5:0] dly,
	output logic            sync_ready_in,
	output logic            async_ready_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] cnt_r;

	always_ff @(posedge clk) begin
		if (sel_any_n)
			cnt_r <= 6'h00;
		else if (cnt_r != dly)
			cnt_r <= cnt_r + 6'h01;
	end
	// ready only while selected, pulled low when released
	assign sync_ready_in  = !sel_any_n && !slow && (cnt_r == dly);
	assign async_ready_in = !sel_any_n && slow && (cnt_r == dly);
endmodule : csru_mem_model

// >>> bench/csru_monitor.sv
// Purpose: port checks of the chip select and ready unit
// Assumes: registers change only between bus cycles
// Notes:   upper and lower sizes mirrored by snooping writes
module csru_monitor (
	input wire logic                       clk,
	input wire logic                       resetn,
	input wire logic                       hsel,
	input wire logic [31:0]                haddr,
	input wire logic [1:0]                 htrans,
	input wire logic                       hwrite,
	input wire logic [31:0]                hwdata,
	input wire logic                       hready,
	input wire logic                       hreadyout,
	input wire logic                       hresp,
	input wire csru_pkg::csru_cyc_t        cyc,
	input wire logic                       bus_grant_ack,
	input wire logic                       upper_mem_select_n,
	input wire logic                       lower_mem_select_n,
	input wire logic [csru_pkg::N_MID-1:0] mid_mem_selects_n,
	input wire logic [csru_pkg::N_PER-1:0] periph_selects_n,
	input wire logic                       int_ready,
	input wire logic                       ext_data_ignore
);
	logic [7:0]  wa_r;
	logic [7:0]  usz_r;
	logic [7:0]  lsz_r;
	logic        wv_r;
	logic        lx_r;
	logic        lio_r;
	logic [19:0] la_r;
	logic        quiet;
	logic        opt_r;
	logic        xstart;
	logic        sel_on;
	// outputs five and six may carry address bits, so they are left out
	assign quiet = upper_mem_select_n & lower_mem_select_n & (&mid_mem_selects_n)
		& (&periph_selects_n[4:0]);
	// with the address option off, outputs five and six are plain selects
	assign sel_on = !quiet || (!opt_r && !(&periph_selects_n[6:5]));
	assign xstart = cyc.start && (cyc.ext_master || bus_grant_ack);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wv_r <= 1'b0;
			wa_r <= 8'h00;
		end else begin
			wv_r <= hsel & hready & htrans[1] & hwrite;
			wa_r <= haddr[7:0];
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			usz_r <= csru_pkg::UPPER_SIZE_RST;
			lsz_r <= 8'h00;
			opt_r <= 1'b0;
		end else if (wv_r && wa_r == csru_pkg::OFS_UPPER) begin
			usz_r <= hwdata[15:8];
		end else if (wv_r && wa_r == csru_pkg::OFS_LOWER) begin
			lsz_r <= hwdata[15:8];
		end else if (wv_r && wa_r == csru_pkg::OFS_MPC) begin
			opt_r <= hwdata[7];
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			la_r <= 20'h00000;
			lio_r <= 1'b0;
			lx_r <= 1'b0;
		end else if (cyc.start) begin
			la_r <= cyc.addr;
			lio_r <= cyc.is_io;
			lx_r <= cyc.ext_master | bus_grant_ack;
		end
	end

	a_ext_no_sel: assert property (xstart |=> ##1 quiet[*3])
		else $error("select active in an external cycle");
	a_ext_no_rdy: assert property (xstart |=> !int_ready[*8])
		else $error("ready given to an external cycle");
	a_upper_range: assert property (!upper_mem_select_n |->
		!lio_r && ~la_r[19:10] <= {2'b00, usz_r})
		else $error("upper select outside its block");
	a_lower_range: assert property (!lower_mem_select_n |->
		!lio_r && la_r[19:10] <= {2'b00, lsz_r})
		else $error("lower select outside its block");
	a_ctrl_ignore: assert property ($rose(ext_data_ignore) |-> la_r[19:8] == 12'hFFF && !lx_r)
		else $error("data ignore outside the control block");
	a_rdy_pulse: assert property (int_ready |=> !int_ready)
		else $error("ready longer than one cycle");
	a_sel_gets_rdy: assert property ($fell(quiet) |-> ##[0:90] int_ready)
		else $error("selected access got no ready");
	a_rdy_needs_sel: assert property (int_ready |-> ##[0:1] sel_on)
		else $error("ready without any select");
	a_ahb_okay: assert property (hsel |-> hreadyout && !hresp)
		else $error("bus response not ready okay");
endmodule : csru_monitor

bind csru_top csru_monitor chk_i (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .cyc(cyc), .bus_grant_ack(bus_grant_ack),
	.upper_mem_select_n(upper_mem_select_n), .lower_mem_select_n(lower_mem_select_n),
	.mid_mem_selects_n(mid_mem_selects_n), .periph_selects_n(periph_selects_n),
	.int_ready(int_ready), .ext_data_ignore(ext_data_ignore));

// >>> bench/tb.sv
// Purpose: self-checking bench for the chip select and ready unit
// Assumes: memory model answers external ready while selected
// Notes:   random sizes and addresses from a fixed seed
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk = 0;
	logic                resetn = 0;
	logic                hsel = 0;
	logic                hwrite = 0;
	logic [31:0]         haddr = 0;
	logic [31:0]         hwdata = 0;
	logic [1:0]          htrans = 0;
	logic [2:0]          hsize = csru_pkg::HSIZE_WORD;
	logic                bus_grant_ack = 0;
	csru_pkg::csru_cyc_t cyc = '0;
	logic                slow = 0;
	logic [5:0]          dly = 6'h14;
	logic                hready, hreadyout, hresp, async_ready_in, sync_ready_in;
	logic                upper_mem_select_n, lower_mem_select_n, int_ready, ext_data_ignore;
	logic [31:0]         hrdata, rd;
	logic [3:0]          mid_mem_selects_n;
	logic [6:0]          periph_selects_n;
	logic [12:0]         sel, sel_now;
	logic [19:0]         a, b, p;
	logic [7:0]          s, q;
	logic                ig;
	int                  num_errors = 0, tests_run = 0, n, got;

	assign hready = hreadyout;
	assign sel_now = {upper_mem_select_n, lower_mem_select_n, mid_mem_selects_n, periph_selects_n};
	always #50 clk = ~clk;

	csru_top uut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cyc(cyc), .bus_grant_ack(bus_grant_ack),
		.async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in),
		.upper_mem_select_n(upper_mem_select_n), .lower_mem_select_n(lower_mem_select_n),
		.mid_mem_selects_n(mid_mem_selects_n), .periph_selects_n(periph_selects_n),
		.int_ready(int_ready), .ext_data_ignore(ext_data_ignore));
	// outputs five and six may carry address bits, so the devices do not answer on them
	csru_mem_model mem (.clk(clk), .sel_any_n(&{sel_now[12:7], sel_now[4:0]}),
		.slow(slow), .dly(dly),
		.sync_ready_in(sync_ready_in), .async_ready_in(async_ready_in));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [7:0] ofs, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, ofs};
		htrans <= csru_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	// one bus cycle; got is the sample count at which ready showed, 0 if none
	task automatic bcyc(input logic [19:0] ad, input logic io, input logic xm);
		cyc <= '{1'b1, 1'b0, ad, io, !io, xm};
		@(posedge clk);
		cyc.start <= 1'b0;
		n = 1;
		got = 0;
		ig = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (n == 3)
				sel = sel_now;
			ig |= ext_data_ignore;
			if (int_ready === 1'b1 && got == 0)
				got = n;
		end while ((got == 0 || n < 5) && n < 90);
		@(posedge clk);
		cyc.done <= (got == 0);
		@(posedge clk);
		cyc.done <= 1'b0;
		@(posedge clk);
	endtask : bcyc

	task automatic end_sim;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	initial begin
		#3000000;
		num_errors++;
		end_sim();
	end

	initial begin
		void'($urandom(38));
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		chk(sel_now, 13'h1FFF);
		ahb(0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		bcyc(20'hFFFF0, 0, 0);
		chk(sel, 13'h0FFF);
		chk(got >= 5, 1);
		bcyc(20'hFFFF0, 0, 1);
		chk({sel, got != 0}, 14'h3FFE);
		bus_grant_ack <= 1'b1;
		bcyc(20'hFFFF0, 0, 0);
		chk({sel, got != 0}, 14'h3FFE);
		bus_grant_ack <= 1'b0;
		bcyc(20'h00100, 0, 0);
		chk(sel, 13'h1FFF);
		ahb(0, csru_pkg::OFS_LOWER, 32'h0);
		chk(rd, 32'h0);
		bcyc(20'h00100, 0, 0);
		chk(sel, 13'h17FF);
		bcyc(20'h00100, 1, 0);
		chk(sel, 13'h1FFF);
		for (int c = 0; c < 8; c++) begin
			s = 8'($urandom % 8);
			slow <= c[0];
			ahb(1, csru_pkg::OFS_LOWER, {16'h0, s, 5'h0, 3'(c)});
			bcyc(20'($urandom % ((32'(s) + 1) << 10)), 0, 0);
			chk(sel, 13'h17FF);
			if (c > 3)
				chk(got, 2 + c % 4);
			else
				chk(got >= 20, 1);
			bcyc(20'((32'(s) + 1) << 10), 0, 0);
			chk(sel, 13'h1FFF);
		end
		// base is a whole multiple of the four-quarter block
		q = 8'($urandom % 4);
		b = 20'((2 + $urandom % 8) * (32'(q) + 1) * 4096);
		ahb(1, csru_pkg::OFS_MID_BASE, {12'h0, b});
		bcyc(b, 0, 0);
		chk(sel, 13'h1FFF);
		ahb(1, csru_pkg::OFS_MPC, {16'h0, q, 8'h04});
		for (int i = 0; i < 4; i++) begin
			bcyc(b + 20'(i * (q + 1) * 1024 + $urandom % 1024), 0, 0);
			chk(sel, 13'h1FFF ^ (13'h80 << i));
			chk(got, 2);
		end
		p = {4'hC, 6'($urandom), 10'h0};
		ahb(1, csru_pkg::OFS_PBC, {12'h0, p[19:10], 10'h044});
		ahb(0, csru_pkg::OFS_PBC, 32'h0);
		chk(rd, {12'h0, p[19:10], 10'h044});
		for (int i = 0; i < 8; i++) begin
			bcyc(p + 20'(i * 128 + $urandom % 128), 1, 0);
			chk(sel, i < 7 ? 13'h1FFF ^ (13'h1 << i) : 13'h1FFF);
		end
		bcyc(p, 0, 0);
		chk(sel, 13'h1FFF);
		ahb(1, csru_pkg::OFS_MPC, {16'h0, q, 8'h84});
		a = {4'h8, 16'($urandom)};
		bcyc(a, 0, 0);
		chk(sel, {6'h3F, a[2], a[1], 5'h1F});
		// overlap with equal ready settings, as software must give
		ahb(1, csru_pkg::OFS_PBC, 32'h7);
		bcyc(20'h00010, 0, 0);
		chk(sel, 13'h179E);
		chk(got, 5);
		bcyc(20'hFFF10, 0, 0);
		chk(ig, 1);
		chk(sel[12], 0);
		end_sim();
	end
endmodule : tb
